/* File: rtl/lsr_cfg.svh */
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH

// ----------------------------------------------------------------
// Clock and array
// ----------------------------------------------------------------
`define LSR_CLK_PERIOD_NS 40
`define LSR_WORDS 1024
`define LSR_ADDR_W 10
`define LSR_CNT_W 8
`define LSR_SYNC_STAGES 2

// ----------------------------------------------------------------
// Strobe timing, fastest grade, in ns
// ----------------------------------------------------------------
`define LSR_MIN_CYCLE_TIME_NS 350
`define LSR_MIN_LOW_PULSE_NS 250
`define LSR_MIN_HIGH_PULSE_NS 100
`define LSR_MIN_WRITE_PULSE_NS 130
`define LSR_SELECT_SETUP_TO_WRITE_END_NS 130
`define LSR_ENABLE_HOLD_TO_WRITE_END_NS 130

// ----------------------------------------------------------------
// Derived cycle counts, minimum times round up
// ----------------------------------------------------------------
`define LSR_CEIL_CYC(ns) (((ns) + `LSR_CLK_PERIOD_NS - 1) / `LSR_CLK_PERIOD_NS)
`define LSR_MIN_CYCLE_CYC `LSR_CEIL_CYC(`LSR_MIN_CYCLE_TIME_NS)
`define LSR_MIN_LOW_CYC `LSR_CEIL_CYC(`LSR_MIN_LOW_PULSE_NS)
`define LSR_MIN_HIGH_CYC `LSR_CEIL_CYC(`LSR_MIN_HIGH_PULSE_NS)
`define LSR_MIN_WRITE_CYC `LSR_CEIL_CYC(`LSR_MIN_WRITE_PULSE_NS)
`define LSR_SEL_SETUP_CYC `LSR_CEIL_CYC(`LSR_SELECT_SETUP_TO_WRITE_END_NS)
`define LSR_EN_HOLD_CYC `LSR_CEIL_CYC(`LSR_ENABLE_HOLD_TO_WRITE_END_NS)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LSR_STROBE_IDLE 1'b1
`define LSR_ADDR_RST 10'h000
`define LSR_DATA_RST 1'b0

`endif

/* File: rtl/lsr_host.sv */
// Behaviour
// - Successive enable falls are at least 350 ns apart.
// - Enable stays low at least 250 ns; read data valid by then.
// - Enable stays high at least 100 ns between accesses.
// - Write strobe low at least 130 ns; bit stored on its rise.
// - Selects low at least 130 ns before write strobe rises. With DUAL_SELECT clear the selects stay high.
// - Enable low at least 130 ns before write strobe rises.
`timescale 1ns/10ps
`default_nettype none
`include "lsr_cfg.svh"

module lsr_host #(
  parameter bit DUAL_SELECT = 1'b1
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire lsr_pkg::lsr_addr_t addr_in,
  input wire logic wdata_in,
  output logic ready_out,
  output logic rdata_out,
  output logic rvalid_out,
  output logic ram_en_n_out,
  output logic ram_select_line_one_n_out,
  output logic ram_select_line_two_n_out,
  output logic ram_we_n_out,
  output var lsr_pkg::lsr_addr_t ram_addr_out,
  output logic ram_d_out,
  input wire logic ram_q_in
);
  import lsr_pkg::*;

  // ----------------------------------------------------------------
  // Phase lengths
  // ----------------------------------------------------------------
  localparam int LOW_CYC = `LSR_MIN_LOW_CYC;
  // Write strobe must cover its own width and both setups to its rise
  localparam int WRP_A = (`LSR_MIN_WRITE_CYC > `LSR_SEL_SETUP_CYC) ?
                         `LSR_MIN_WRITE_CYC : `LSR_SEL_SETUP_CYC;
  localparam int WRP_CYC = (WRP_A > `LSR_EN_HOLD_CYC) ? WRP_A : `LSR_EN_HOLD_CYC;
  localparam int WR_TAIL = (LOW_CYC > WRP_CYC) ? (LOW_CYC - WRP_CYC) : 1;
  // Reads hold enable past the access time so the synchroniser catches the bit
  localparam int RD_CYC = LOW_CYC + `LSR_SYNC_STAGES;
  localparam lsr_cnt_t WRP_LOAD = lsr_cnt_t'(WRP_CYC - 1);
  localparam lsr_cnt_t TAIL_LOAD = lsr_cnt_t'(WR_TAIL - 1);
  localparam lsr_cnt_t RD_LOAD = lsr_cnt_t'(RD_CYC - 1);
  localparam lsr_cnt_t HIGH_LOAD = lsr_cnt_t'(`LSR_MIN_HIGH_CYC - 1);
  localparam lsr_cnt_t CYC_LOAD = lsr_cnt_t'(`LSR_MIN_CYCLE_CYC - 1);

  lsr_state_t state_r;
  lsr_state_t state_nxt;
  logic ph_load;
  lsr_cnt_t ph_count;
  logic cy_load;
  logic accept;
  logic wr_r;
  logic q_meta_r;
  logic q_sync_r;
  logic en_n_r;
  logic sel_n_r;
  logic we_n_r;
  lsr_addr_t addr_r;
  logic d_r;
  logic rdata_r;
  logic rvalid_r;

  lsr_tmr_if ph_if ();
  lsr_tmr_if cy_if ();

  // ----------------------------------------------------------------
  // Timers: phase length and enable-fall spacing
  // ----------------------------------------------------------------
  assign ph_if.ce = ce_in;
  assign ph_if.load = ph_load;
  assign ph_if.count = ph_count;
  assign cy_if.ce = ce_in;
  assign cy_if.load = cy_load;
  assign cy_if.count = CYC_LOAD;

  lsr_timer u_phase (
    .mclk_in (mclk_in),
    .sys_rst_in (sys_rst_in),
    .tmr_io (ph_if.tmr)
  );

  lsr_timer u_cycle (
    .mclk_in (mclk_in),
    .sys_rst_in (sys_rst_in),
    .tmr_io (cy_if.tmr)
  );

  // ----------------------------------------------------------------
  // Command port
  // ----------------------------------------------------------------
  assign ready_out = ce_in && (state_r == LSR_IDLE) && cy_if.done;
  assign accept = ready_out && req_in;

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      wr_r <= 1'b0;
      addr_r <= `LSR_ADDR_RST;
      d_r <= `LSR_DATA_RST;
    end
    else if (accept)
    begin
      wr_r <= write_in;
      // Address goes out a cycle before enable falls; the part latches it then
      addr_r <= addr_in;
      d_r <= wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    ph_load = 1'b0;
    ph_count = '0;
    cy_load = 1'b0;
    case (state_r)
      LSR_IDLE:
      begin
        if (accept)
        begin
          state_nxt = LSR_SETUP;
        end
      end
      LSR_SETUP:
      begin
        state_nxt = LSR_LOW;
        ph_load = 1'b1;
        ph_count = wr_r ? WRP_LOAD : RD_LOAD;
        cy_load = 1'b1;
      end
      LSR_LOW:
      begin
        if (ph_if.done)
        begin
          ph_load = 1'b1;
          if (!we_n_r)
          begin
            ph_count = TAIL_LOAD;
          end
          else
          begin
            state_nxt = LSR_HIGH;
            ph_count = HIGH_LOAD;
          end
        end
      end
      LSR_HIGH:
      begin
        if (ph_if.done)
        begin
          state_nxt = LSR_IDLE;
        end
      end
      default:
      begin
        state_nxt = LSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      state_r <= LSR_IDLE;
    end
    else if (ce_in)
    begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      en_n_r <= `LSR_STROBE_IDLE;
      sel_n_r <= `LSR_STROBE_IDLE;
      we_n_r <= `LSR_STROBE_IDLE;
    end
    else if (ce_in)
    begin
      case (state_r)
        LSR_SETUP:
        begin
          en_n_r <= 1'b0;
          // Selects fall with enable when DUAL_SELECT is set, ahead of any write strobe rise
          sel_n_r <= !DUAL_SELECT;
          // Strobe only inside an enabled frame
          we_n_r <= !wr_r;
        end
        LSR_LOW:
        begin
          if (ph_if.done)
          begin
            if (!we_n_r)
            begin
              we_n_r <= 1'b1;
            end
            else
            begin
              en_n_r <= 1'b1;
              sel_n_r <= 1'b1;
            end
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      q_meta_r <= 1'b0;
      q_sync_r <= 1'b0;
    end
    else if (ce_in)
    begin
      q_meta_r <= ram_q_in;
      q_sync_r <= q_meta_r;
    end
  end

  // Sampled on the edge that raises enable; the part still drives until then
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_r <= `LSR_DATA_RST;
      rvalid_r <= 1'b0;
    end
    else if (ce_in)
    begin
      rvalid_r <= 1'b0;
      if ((state_r == LSR_LOW) && ph_if.done && we_n_r && !wr_r)
      begin
        rdata_r <= q_sync_r;
        rvalid_r <= 1'b1;
      end
    end
  end

  assign rdata_out = rdata_r;
  assign rvalid_out = rvalid_r;
  assign ram_en_n_out = en_n_r;
  assign ram_select_line_one_n_out = sel_n_r;
  assign ram_select_line_two_n_out = sel_n_r;
  assign ram_we_n_out = we_n_r;
  assign ram_addr_out = addr_r;
  assign ram_d_out = d_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_en_low_hold;
    (en_n_r == 1'b0) [*7];
  endsequence

  sequence s_we_low_hold;
    (we_n_r == 1'b0) [*4];
  endsequence

  sequence s_sel_before_rise;
    ($past(sel_n_r, 1) == 1'b0) && ($past(sel_n_r, 2) == 1'b0) &&
    ($past(sel_n_r, 3) == 1'b0) && ($past(sel_n_r, 4) == 1'b0);
  endsequence

  AST_CYCLE_SPACING: assert property ($fell(en_n_r) |=> (!$fell(en_n_r)) [*8])
    else $error("enable falls closer than minimum cycle time");
  AST_LOW_PULSE: assert property ($fell(en_n_r) |-> s_en_low_hold)
    else $error("enable low pulse too short");
  AST_HIGH_PULSE: assert property ($rose(en_n_r) |-> en_n_r [*3])
    else $error("enable high pulse too short");
  AST_WRITE_PULSE: assert property ($fell(we_n_r) |-> s_we_low_hold)
    else $error("write strobe pulse too short");
  AST_SEL_SETUP: assert property (($rose(we_n_r) && DUAL_SELECT) |-> s_sel_before_rise)
    else $error("selects not low long enough before write end");
  AST_EN_HOLD: assert property ($rose(we_n_r) |-> ($past(en_n_r, 4) == 1'b0) &&
                                (en_n_r == 1'b0))
    else $error("enable not low long enough before write end");
  AST_WE_GATED: assert property ((we_n_r == 1'b0) |-> (en_n_r == 1'b0))
    else $error("write strobe outside enabled frame");
  AST_READ_SAMPLE: assert property ($rose(rvalid_r) |-> $rose(en_n_r) && we_n_r &&
                                    ($past(en_n_r, 8) == 1'b0))
    else $error("read sampled outside a long enough enabled frame");

endmodule

`default_nettype wire

/* File: rtl/lsr_pkg.sv */
`include "lsr_cfg.svh"

package lsr_pkg;

  typedef logic [`LSR_ADDR_W-1:0] lsr_addr_t;
  typedef logic [`LSR_CNT_W-1:0] lsr_cnt_t;

  // Gray sequence idle -> setup -> low -> high -> idle
  typedef enum logic [1:0]
  {
    LSR_IDLE = 2'h0,
    LSR_SETUP = 2'h1,
    LSR_LOW = 2'h3,
    LSR_HIGH = 2'h2
  } lsr_state_t;

endpackage

/* File: rtl/lsr_timer.sv */
`timescale 1ns/10ps
`default_nettype none

module lsr_timer (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  lsr_tmr_if.tmr tmr_io
);
  import lsr_pkg::*;

  lsr_cnt_t cnt_r;

  // Loading N raises done N edges later; idle timer reads as done
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      cnt_r <= '0;
    end
    else if (tmr_io.ce)
    begin
      if (tmr_io.load)
      begin
        cnt_r <= tmr_io.count;
      end
      else if (cnt_r != '0)
      begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  assign tmr_io.done = (cnt_r == '0);

endmodule

`default_nettype wire

/* File: rtl/lsr_tmr_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface lsr_tmr_if;
  import lsr_pkg::*;
  logic ce;
  logic load;
  lsr_cnt_t count;
  logic done;
  modport ctl (output ce, output load, output count, input done);
  modport tmr (input ce, input load, input count, output done);
endinterface

`default_nettype wire

/* File: test/lsr_host_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lsr_cfg.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module lsr_host_test;
  import lsr_pkg::*;
  logic mclk_in, sys_rst_in, ce_in, req_in, write_in, wdata_in, slow;
  lsr_addr_t addr_in, ram_addr, a;
  logic ready, rdata, rvalid, en_n, sl_one_n, sl_two_n, we_n, d, q;
  int viol, err_total, total_checks, cyc;
  logic ready_s, rdata_s, rvalid_s, en_n_s, sl_one_n_s, sl_two_n_s, we_n_s, d_s, q_s;
  lsr_addr_t ram_addr_s;
  int viol_s;
  bit ref_mem [int];

  lsr_host u_lsr_host (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .req_in(req_in), .write_in(write_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .ready_out(ready), .rdata_out(rdata), .rvalid_out(rvalid), .ram_en_n_out(en_n),
    .ram_select_line_one_n_out(sl_one_n), .ram_select_line_two_n_out(sl_two_n),
    .ram_we_n_out(we_n), .ram_addr_out(ram_addr), .ram_d_out(d), .ram_q_in(q));
  lsr_ram_model u_lsr_ram_model (.en_n_in(en_n), .sl_one_n_in(sl_one_n),
    .sl_two_n_in(sl_two_n), .we_n_in(we_n), .addr_in(ram_addr), .d_in(d),
    .slow_in(slow), .q_out(q), .viol_out(viol));

  // Same stimulus into a single-select build, so that mode is exercised too
  if (1)
  begin : g_single
    lsr_host #(.DUAL_SELECT(1'b0)) u_lsr_host (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .ce_in(ce_in), .req_in(req_in), .write_in(write_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .ready_out(ready_s), .rdata_out(rdata_s), .rvalid_out(rvalid_s),
      .ram_en_n_out(en_n_s), .ram_select_line_one_n_out(sl_one_n_s),
      .ram_select_line_two_n_out(sl_two_n_s), .ram_we_n_out(we_n_s),
      .ram_addr_out(ram_addr_s), .ram_d_out(d_s), .ram_q_in(q_s));
    lsr_ram_model #(.DUAL(1'b0)) u_lsr_ram_model (.en_n_in(en_n_s), .sl_one_n_in(sl_one_n_s),
      .sl_two_n_in(sl_two_n_s), .we_n_in(we_n_s), .addr_in(ram_addr_s), .d_in(d_s),
      .slow_in(slow), .q_out(q_s), .viol_out(viol_s));
  end

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_total++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    `CHK("timing", 0, viol)
    `CHK("timing_single", 0, viol_s)
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic do_reset(input int n);
    sys_rst_in = 1'b1;
    repeat (n) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    `CHK("en_idle", 1'b1, en_n)
    `CHK("we_idle", 1'b1, we_n)
    `CHK("sel_idle", 2'h3, {sl_one_n, sl_two_n})
    `CHK("sel_single_idle", 2'h3, {sl_one_n_s, sl_two_n_s})
    `CHK("rvalid_rst", 1'b0, rvalid)
    `CHK("addr_rst", 10'h000, ram_addr)
  endtask

  // Frozen ops drop the clock enable mid-access; the enable strobe must hold still
  task automatic op(input bit w, input lsr_addr_t ad, input bit dv, input bit frz);
    int n;
    logic en_s;
    n = 0;
    while (ready !== 1'b1 && n < 40)
    begin
      @(negedge mclk_in);
      n++;
    end
    `CHK("ready", 1'b1, ready)
    `CHK("ready_single", 1'b1, ready_s)
    req_in = 1'b1;
    write_in = w;
    addr_in = ad;
    wdata_in = dv;
    @(negedge mclk_in);
    if (w)
      `CHK("ram_d", dv, d)
    req_in = 1'b0;
    addr_in = ~ad;
    wdata_in = ~dv;
    if (frz)
    begin
      repeat (3) @(negedge mclk_in);
      ce_in = 1'b0;
      en_s = en_n;
      repeat (5) @(negedge mclk_in);
      `CHK("en_frozen", en_s, en_n)
      `CHK("ready_frozen", 1'b0, ready)
      `CHK("sel_single_open", 2'h3, {sl_one_n_s, sl_two_n_s})
      ce_in = 1'b1;
    end
    if (w)
      ref_mem[ad] = dv;
    else
    begin
      n = 0;
      while (rvalid !== 1'b1 && n < 30)
      begin
        @(negedge mclk_in);
        n++;
      end
      `CHK("rvalid", 1'b1, rvalid)
      `CHK("rdata", ref_mem.exists(ad) ? ref_mem[ad] : 1'b0, rdata)
      `CHK("ram_addr", ad, ram_addr)
      `CHK("rvalid_single", 1'b1, rvalid_s)
      `CHK("rdata_single", ref_mem.exists(ad) ? ref_mem[ad] : 1'b0, rdata_s)
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst_in = 1'b1;
    ce_in = 1'b1;
    req_in = 1'b0;
    write_in = 1'b0;
    addr_in = 10'h000;
    wdata_in = 1'b0;
    slow = 1'b0;
    void'($urandom(32'hD78DDF4F));
    do_reset(10);
    op(1'b1, 10'h000, 1'b1, 1'b0);
    op(1'b1, 10'h3FF, 1'b1, 1'b0);
    op(1'b0, 10'h000, 1'b0, 1'b0);
    op(1'b0, 10'h3FF, 1'b0, 1'b0);
    op(1'b1, 10'h3FF, 1'b0, 1'b1);
    op(1'b0, 10'h3FF, 1'b0, 1'b1);
    slow = 1'b1;
    op(1'b0, 10'h000, 1'b0, 1'b0);
    repeat (150)
    begin
      slow = 1'($urandom);
      a = 10'($urandom);
      op(1'($urandom), a, 1'($urandom), 1'($urandom_range(0, 7) == 0));
    end
    // Let the last frame close first; a cut frame would break the part's pulse widths
    while (ready !== 1'b1)
    begin
      @(negedge mclk_in);
    end
    do_reset(2);
    op(1'b0, 10'h000, 1'b0, 1'b0);
    op(1'b0, 10'h3FF, 1'b0, 1'b0);
    end_of_test();
  end
endmodule

`default_nettype wire

/* File: test/lsr_ram_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lsr_cfg.svh"

module lsr_ram_model #(
  parameter bit DUAL = 1'b1
) (
  input wire logic en_n_in,
  input wire logic sl_one_n_in,
  input wire logic sl_two_n_in,
  input wire logic we_n_in,
  input wire lsr_pkg::lsr_addr_t addr_in,
  input wire logic d_in,
  input wire logic slow_in,
  output logic q_out,
  output int viol_out
);
  import lsr_pkg::*;
  logic mem [`LSR_WORDS];
  lsr_addr_t lat_r;
  logic ok_r;
  logic sel;
  realtime tef, teh, twf, tsf;

  initial
  begin
    foreach (mem[i]) mem[i] = 1'b0;
    tef = -1.0e6;
    teh = tef;
    twf = tef;
    tsf = tef;
    viol_out = 0;
    ok_r = 1'b0;
  end

  assign sel = !DUAL || (!sl_one_n_in && !sl_two_n_in);
  // Off-window output shows the inverse, so a badly timed sample never matches
  assign q_out = (!en_n_in && sel && we_n_in && ok_r) ? mem[lat_r] : ~mem[lat_r];

  always @(negedge en_n_in)
  begin
    lat_r = addr_in;
    ok_r = 1'b0;
    ok_r <= #(slow_in ? 240 : 20) 1'b1;
    if ($realtime - tef < 350) viol_out++;
    if ($realtime - teh < 100) viol_out++;
    tef = $realtime;
  end

  always @(posedge en_n_in)
  begin
    if ($realtime - tef < 250) viol_out++;
    teh = $realtime;
  end

  always @(negedge sl_one_n_in) tsf = $realtime;
  always @(negedge we_n_in) twf = $realtime;

  always @(posedge we_n_in)
  begin
    if ($realtime - twf < 130) viol_out++;
    if ($realtime - tef < 130) viol_out++;
    if (DUAL && $realtime - tsf < 130) viol_out++;
    if (!en_n_in && sel) mem[lat_r] = d_in;
  end
endmodule

`default_nettype wire
